/* File: include/cpf_cfg.svh */
// constants for the card punch function control: offsets, fields, counts
// assumes a 32-bit apb master and a 24-bit word memory port with mod-3 check bits
`ifndef CPF_CFG_SVH
`define CPF_CFG_SVH
`define CPF_OFF_FUNC 8'h00
`define CPF_OFF_CTRL 8'h04
`define CPF_OFF_STAT 8'h08
`define CPF_OFF_CLR 8'h0C
`define CPF_OFF_CNT 8'h10
`define CPF_CTRL_ONLINE 0
`define CPF_CTRL_ACLR 1
`define CPF_CTRL_COL90 2
`define CPF_FW_STACK 19
`define CPF_FW_XLAT 18
`define CPF_FW_FEED 17
`define CPF_FW_INTR 16
`define CPF_FW_TOP 25
`define CPF_FW_CHK_HI 31
`define CPF_FW_CHK_LO 30
`define CPF_ST_PEND 8
`define CPF_ST_ARM 9
`define CPF_ST_BUSY 10
`define CPF_IND_INIT 2
`define CPF_IND_DATA 5
`define CPF_IND_OVER 6
`define CPF_IND_FAULT 7
`define CPF_OP_PC 3'h1
`define CPF_OP_PCT 3'h3
`define CPF_OP_PCS 3'h5
`define CPF_OP_PUNCH_TRANSLATED_STACKER1 3'h7
`define CPF_OP_CCS 3'h4
`define CPF_W80U 6'h28
`define CPF_W80T 6'h14
`define CPF_W90 6'h18
`define CPF_ACC80 8'hF0
`define CPF_ACC90 8'h90
`endif

/* File: include/cpf_pkg.sv */
// types shared by the card punch function control
// assumes cpf_cfg.svh supplies the numeric constants
`default_nettype none
package cpf_pkg;
  // card cycle sequencer states
  typedef enum logic [1:0] {CPF_IDLE, CPF_FETCH, CPF_HOLD} cpf_state_e;
endpackage
`default_nettype wire

/* File: core/cpf_mod3.sv */
// modulo-3 residue check of one memory word against its two check bits
// assumes the check bits hold the residue of the data taken as an unsigned number
`default_nettype none
module cpf_mod3 #(
  parameter int W = 24
) (
  input wire logic [W-1:0] data, // word under test
  input wire logic [1:0] chk, // residue carried with the word
  output logic ok // residue matches
);
  logic [1:0] res [0:W];

  assign res[0] = 2'h0;
  // msb first: each step folds one bit in as (2r + b) mod 3
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic [2:0] t;
      assign t = {res[i], 1'b0} + {2'h0, data[W-1-i]};
      assign res[i+1] = (t >= 3'h3) ? 2'(t - 3'h3) : t[1:0];
    end
  endgenerate
  assign ok = (res[W] == chk);
endmodule // cpf_mod3
`default_nettype wire

/* File: core/cpf_punch_ctrl.sv */
// card punch function control: apb registers, function word decode,
// card cycle sequencing, data fetch and the four interrupt indicators
// assumes mechanism pins are asynchronous and the memory port is on pclk
`include "cpf_cfg.svh"
`default_nettype none
module cpf_punch_ctrl
  import cpf_pkg::*;
#(
  parameter int AW = 16
) (
  input wire logic pclk, // 125 MHz bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // unmapped address
  output logic mem_req, // memory read request
  output logic [AW-1:0] mem_addr, // memory word address
  input wire logic mem_gnt, // access granted, data valid
  input wire logic mem_err, // access failed
  input wire logic [23:0] mem_rdata, // memory word
  input wire logic [1:0] mem_rchk, // word mod-3 residue
  output logic [23:0] punch_data, // word to the punch
  output logic punch_valid, // punch_data strobe
  output logic punch_xlat, // translate image to card code
  output logic stacker_sel, // deflector to stacker 1
  output logic feed_card, // feed and advance pulse
  output logic select_only, // move checked card only
  input wire logic card_done_pin, // card cycle end
  input wire logic hole_err_pin, // hole count mismatch
  input wire logic fault_pin, // jam or fault condition
  input wire logic oversight_pin, // operator oversight condition
  input wire logic path_busy_pin // cards present in path
);
  cpf_state_e st;
  logic s1 [0:4];
  logic s2 [0:4];
  logic s3 [0:4];
  logic [4:0] ev;
  logic online, col90, clr_arm;
  logic sb_pend;
  logic [31:0] sb_word;
  logic [25:0] fw;
  logic cyc_col90, cyc_claim, derr_pend;
  logic ind_init, ind_data, ind_over, ind_fault;
  logic [7:0] req_cnt, gnt_cnt, target;
  logic [5:0] widx, words;
  logic wr, hit, blocked, start, fs_ok, op_ok, card_end, qual;
  logic fault_ev, over_ev, dat_ok, feedcyc, claimed;
  logic [2:0] op;

  // two-flop synchronisers, third flop only for edge detection
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      logic pin;
      assign pin = (g == 0) ? card_done_pin : (g == 1) ? hole_err_pin :
                   (g == 2) ? fault_pin : (g == 3) ? oversight_pin : path_busy_pin;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
        end else begin
          s1[g] <= pin;
          s2[g] <= s1[g];
          s3[g] <= s2[g];
        end
      end
      assign ev[g] = s2[g] & ~s3[g];
    end
  endgenerate

  // apb decode: zero wait state, error on unmapped offsets
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  always_comb begin
    hit = 1'b1;
    prdata = 32'h0000_0000;
    if (paddr == `CPF_OFF_FUNC) begin
      prdata = sb_word;
    end else if (paddr == `CPF_OFF_CTRL) begin
      prdata[`CPF_CTRL_ONLINE] = online;
      prdata[`CPF_CTRL_COL90] = col90;
    end else if (paddr == `CPF_OFF_STAT) begin
      prdata[`CPF_IND_INIT] = ind_init;
      prdata[`CPF_IND_DATA] = ind_data;
      prdata[`CPF_IND_OVER] = ind_over;
      prdata[`CPF_IND_FAULT] = ind_fault;
      prdata[`CPF_ST_PEND] = sb_pend;
      prdata[`CPF_ST_ARM] = clr_arm;
      prdata[`CPF_ST_BUSY] = (st != CPF_IDLE);
    end else if (paddr == `CPF_OFF_CLR) begin
      prdata = 32'h0000_0000;
    end else if (paddr == `CPF_OFF_CNT) begin
      prdata[7:0] = gnt_cnt;
    end else begin
      hit = 1'b0;
    end
  end
  assign pslverr = psel & penable & ~hit;

  // mod-3 checks on the pending word and on each fetched data word
  cpf_mod3 #(.W(24)) u_fs_chk (
    .data(sb_word[23:0]),
    .chk(sb_word[`CPF_FW_CHK_HI:`CPF_FW_CHK_LO]),
    .ok(fs_ok)
  );
  cpf_mod3 #(.W(24)) u_dat_chk (
    .data(mem_rdata),
    .chk(mem_rchk),
    .ok(dat_ok)
  );

  // any pending indicator except initiation stops memory and new cycles
  assign blocked = ind_data | ind_fault | ind_over;
  assign op = sb_word[`CPF_FW_STACK:`CPF_FW_FEED];
  assign op_ok = (op == `CPF_OP_PC) | (op == `CPF_OP_PCT) | (op == `CPF_OP_PCS) |
                 (op == `CPF_OP_PUNCH_TRANSLATED_STACKER1) | (op == `CPF_OP_CCS);
  assign start = (st == CPF_IDLE) & sb_pend & online & ~blocked;
  assign card_end = (st != CPF_IDLE) & ev[0];
  assign qual = online & (sb_pend | s2[4] | (st != CPF_IDLE));
  // unknown operation or a bad residue on the function word counts as a fault
  assign fault_ev = ev[2] | (start & (~fs_ok | ~op_ok));
  assign over_ev = ev[3];
  assign feedcyc = fw[`CPF_FW_FEED];
  // a claim only counts inside a running cycle, so a stale one never masks a new start
  assign claimed = cyc_claim & (st != CPF_IDLE);
  assign words = cyc_col90 ? `CPF_W90 : (fw[`CPF_FW_XLAT] ? `CPF_W80T : `CPF_W80U);
  assign target = cyc_col90 ? `CPF_ACC90 : `CPF_ACC80;

  // control register: on-line, column format, clear-button arming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      online <= 1'b0;
      col90 <= 1'b0;
      clr_arm <= 1'b0;
    end else begin
      if (wr && paddr == `CPF_OFF_CTRL) begin
        online <= pwdata[`CPF_CTRL_ONLINE];
        col90 <= pwdata[`CPF_CTRL_COL90];
      end
      // the clear button arms software reset of fault and oversight
      if (wr && paddr == `CPF_OFF_CTRL && pwdata[`CPF_CTRL_ACLR])
        clr_arm <= 1'b1;
      else if (!ind_fault && !ind_over)
        clr_arm <= 1'b0;
    end
  end

  // standby word: a new word written in the load cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sb_pend <= 1'b0;
      sb_word <= 32'h0000_0000;
    end else begin
      if (wr && paddr == `CPF_OFF_FUNC) begin
        sb_pend <= 1'b1;
        sb_word <= pwdata;
      end else if (start) begin
        sb_pend <= 1'b0;
      end
    end
  end

  // card cycle sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= CPF_IDLE;
      fw <= 26'h000_0000;
      cyc_col90 <= 1'b0;
    end else begin
      case (st)
        CPF_IDLE: begin
          if (start) begin
            fw <= sb_word[`CPF_FW_TOP:0];
            cyc_col90 <= col90;
            if (!fs_ok || !op_ok)
              st <= CPF_IDLE;
            else if (sb_word[`CPF_FW_FEED])
              st <= CPF_FETCH;
            else
              st <= CPF_HOLD;
          end
        end
        CPF_FETCH: begin
          if (ev[0])
            st <= CPF_IDLE;
          else if (req_cnt == target)
            st <= CPF_HOLD;
        end
        CPF_HOLD: begin
          if (ev[0])
            st <= CPF_IDLE;
        end
        default: st <= CPF_IDLE;
      endcase
    end
  end

  // memory fetch: walk the card image repeatedly until the access total
  assign mem_req = (st == CPF_FETCH) & ~blocked & (req_cnt != target);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_cnt <= 8'h00;
      gnt_cnt <= 8'h00;
      widx <= 6'h00;
      mem_addr <= '0;
    end else if (start) begin
      req_cnt <= 8'h00;
      gnt_cnt <= 8'h00;
      widx <= 6'h00;
      mem_addr <= sb_word[AW-1:0];
    end else if (mem_req && (mem_gnt || mem_err)) begin
      req_cnt <= req_cnt + 8'h01;
      if (mem_gnt)
        gnt_cnt <= gnt_cnt + 8'h01;
      if (widx + 6'h01 == words) begin
        widx <= 6'h00;
        mem_addr <= fw[AW-1:0];
      end else begin
        widx <= widx + 6'h01;
        mem_addr <= mem_addr + AW'(1);
      end
    end
  end

  // punch side: data word, translation and stacker steering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      punch_data <= 24'h00_0000;
      punch_valid <= 1'b0;
      punch_xlat <= 1'b0;
      stacker_sel <= 1'b0;
      feed_card <= 1'b0;
      select_only <= 1'b0;
    end else begin
      punch_valid <= mem_req & mem_gnt;
      if (mem_req && mem_gnt)
        punch_data <= mem_rdata;
      feed_card <= start & fs_ok & op_ok & sb_word[`CPF_FW_FEED];
      select_only <= start & fs_ok & (op == `CPF_OP_CCS);
      if (start && fs_ok && op_ok) begin
        punch_xlat <= sb_word[`CPF_FW_XLAT];
        stacker_sel <= sb_word[`CPF_FW_STACK];
      end else if (card_end) begin
        stacker_sel <= 1'b0;
      end
    end
  end

  // data error candidates gather through the cycle, judged at its end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      derr_pend <= 1'b0;
    end else if (start) begin
      derr_pend <= 1'b0;
    end else if (st != CPF_IDLE) begin
      if ((mem_req && mem_gnt && !dat_ok) || (mem_req && mem_err) || ev[1])
        derr_pend <= 1'b1;
    end
  end

  // first fault or oversight of a cycle claims it; a tie goes to fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_claim <= 1'b0;
    end else if (start || card_end) begin
      cyc_claim <= start & qual & fault_ev;
    end else if (qual && (fault_ev || over_ev)) begin
      cyc_claim <= 1'b1;
    end
  end

  // initiation: software may clear at any time, a set in that cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_init <= 1'b0;
    end else if (start && sb_word[`CPF_FW_INTR]) begin
      ind_init <= 1'b1;
    end else if (wr && paddr == `CPF_OFF_CLR && pwdata[`CPF_IND_INIT]) begin
      ind_init <= 1'b0;
    end
  end

  // fault and oversight: only one per cycle, reset needs the clear button
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_fault <= 1'b0;
      ind_over <= 1'b0;
    end else begin
      if (qual && fault_ev && !claimed)
        ind_fault <= 1'b1;
      else if (wr && paddr == `CPF_OFF_CLR && pwdata[`CPF_IND_FAULT] && clr_arm)
        ind_fault <= 1'b0;
      if (qual && over_ev && !fault_ev && !claimed)
        ind_over <= 1'b1;
      else if (wr && paddr == `CPF_OFF_CLR && pwdata[`CPF_IND_OVER] && clr_arm)
        ind_over <= 1'b0;
    end
  end

  // data error set late in the cycle, unless fault or oversight claimed it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_data <= 1'b0;
    end else if (card_end && !claimed && !(qual && (fault_ev || over_ev)) &&
                 (derr_pend || (feedcyc && gnt_cnt != target))) begin
      ind_data <= 1'b1;
    end else if (wr && paddr == `CPF_OFF_CLR && pwdata[`CPF_IND_DATA]) begin
      ind_data <= 1'b0;
    end
  end

  // checks
  chk_mem_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    blocked |-> !mem_req) else $error("memory request while indicator pending");
  chk_standby_load: assert property (@(posedge pclk) disable iff (!presetn)
    (start && !(wr && paddr == `CPF_OFF_FUNC)) |=> !sb_pend)
    else $error("standby pending not cleared on load");
  chk_init_set: assert property (@(posedge pclk) disable iff (!presetn)
    (start && sb_word[`CPF_FW_INTR]) |=> ind_init) else $error("initiation not set");
  chk_init_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!ind_init && !(start && sb_word[`CPF_FW_INTR])) |=> !ind_init)
    else $error("initiation set without request");
  chk_fault_qual: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ind_fault) |-> $past(qual)) else $error("fault set while idle or off-line");
  chk_over_qual: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ind_over) |-> $past(qual)) else $error("oversight set while idle or off-line");
  chk_data_yield: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ind_data) |-> !$past(cyc_claim) && !ind_fault && !ind_over)
    else $error("data error set in a claimed cycle");
  chk_one_claim: assert property (@(posedge pclk) disable iff (!presetn)
    !($rose(ind_fault) && $rose(ind_over))) else $error("fault and oversight together");
  chk_bad_op: assert property (@(posedge pclk) disable iff (!presetn)
    (start && fs_ok && !op_ok) |=> ind_fault && st == CPF_IDLE && !feed_card)
    else $error("unknown operation not faulted");
  chk_select_only: assert property (@(posedge pclk) disable iff (!presetn)
    (start && fs_ok && op == `CPF_OP_CCS) |=> stacker_sel && !feed_card && st == CPF_HOLD)
    else $error("select-only misbehaves");
  chk_stacker_home: assert property (@(posedge pclk) disable iff (!presetn)
    card_end |=> !stacker_sel) else $error("deflector not returned");
  chk_count: assert property (@(posedge pclk) disable iff (!presetn)
    (card_end && feedcyc && gnt_cnt != target && !cyc_claim && !(qual && (fault_ev || over_ev)))
    |=> ind_data) else $error("access count error missed");
  cov_punch: cover property (@(posedge pclk) disable iff (!presetn)
    feed_card ##[1:1000] card_end);
  cov_select: cover property (@(posedge pclk) disable iff (!presetn) select_only);
  cov_data_err: cover property (@(posedge pclk) disable iff (!presetn) $rose(ind_data));
  cov_fault: cover property (@(posedge pclk) disable iff (!presetn) $rose(ind_fault));
endmodule // cpf_punch_ctrl
`default_nettype wire

/* File: test/cpf_mem_model.sv */
// memory partner of the punch control: grants each held request after lat idle cycles
// assumes word addresses of at least 16 bits and requests held until granted
`default_nettype none
module cpf_mem_model #(
  parameter int AW = 16
) (
  input wire logic clk, // bus clock
  input wire logic rst_n, // async reset, active low
  input wire logic mem_req, // request level
  input wire logic [AW-1:0] mem_addr, // word address
  input wire logic [1:0] lat, // idle cycles before each grant
  input wire logic corrupt, // send a wrong residue
  output logic mem_gnt, // grant pulse, data valid
  output logic mem_err, // never raised by this model
  output logic [23:0] mem_rdata, // word, toggling pattern between grants
  output logic [1:0] mem_rchk // residue of the word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_cnt;
  logic [23:0] next_word;
  logic [1:0] next_res;
  // word content is derived from its address so the bench can predict it
  assign next_word = {~mem_addr[7:0], mem_addr[15:0]};
  assign next_res = 2'(next_word % 3);
  assign mem_err = 1'b0;
  // idle data lines invert every cycle: a stale word must never look valid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_gnt <= 1'b0;
      wait_cnt <= 2'h0;
      mem_rdata <= 24'h000000;
      mem_rchk <= 2'h0;
    end else if (mem_req && !mem_gnt && wait_cnt >= lat) begin
      mem_gnt <= 1'b1;
      wait_cnt <= 2'h0;
      mem_rdata <= next_word;
      mem_rchk <= corrupt ? ((next_res == 2'h2) ? 2'h0 : next_res + 2'h1) : next_res;
    end else begin
      mem_gnt <= 1'b0;
      mem_rdata <= ~mem_rdata;
      mem_rchk <= ~mem_rchk;
      wait_cnt <= (mem_req && !mem_gnt) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule // cpf_mem_model
`default_nettype wire

/* File: test/card_punch_function_control_tb_top.sv */
// self-checking bench of the card punch function control
// assumes cpf_cfg.svh on the include path and cpf_mem_model as memory partner
`include "cpf_cfg.svh"
`default_nettype none
module card_punch_function_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, rd;
  logic mem_req, mem_gnt, mem_err, punch_valid, punch_xlat, stacker_sel, feed_card, select_only;
  logic [15:0] mem_addr, base, va;
  logic [23:0] mem_rdata, punch_data;
  logic [1:0] mem_rchk, lat;
  logic [3:0] pins; // card done, hole error, fault, oversight
  logic path_busy, corrupt, track, stk_seen, xlat_seen;
  logic [9:0] tbl [13];
  int err_count, checks_done, gcount, vcount, feed_n, sel_n, nwords, hold_sel;
  cpf_punch_ctrl #(.AW(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_gnt(mem_gnt), .mem_err(mem_err), .mem_rdata(mem_rdata), .mem_rchk(mem_rchk),
    .punch_data(punch_data), .punch_valid(punch_valid), .punch_xlat(punch_xlat),
    .stacker_sel(stacker_sel), .feed_card(feed_card), .select_only(select_only),
    .card_done_pin(pins[0]), .hole_err_pin(pins[1]), .fault_pin(pins[2]),
    .oversight_pin(pins[3]), .path_busy_pin(path_busy));
  cpf_mem_model #(.AW(16)) mem (.clk(pclk), .rst_n(presetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .lat(lat), .corrupt(corrupt), .mem_gnt(mem_gnt),
    .mem_err(mem_err), .mem_rdata(mem_rdata), .mem_rchk(mem_rchk));
  // 125 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // function word with reserved bits zero and its residue on top; bad flips the residue
  function automatic logic [31:0] fword(input logic [2:0] op, input logic intr,
      input logic [15:0] l, input logic bad);
    logic [23:0] low;
    logic [1:0] r;
    low = {4'h0, op, intr, l};
    r = 2'(low % 3);
    if (bad) r = (r == 2'h2) ? 2'h0 : r + 2'h1;
    return {r, 6'h00, low};
  endfunction
  // one apb transfer; held until pready is seen high, read data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // pins are sampled through a synchroniser, so each pulse spans several clocks
  task automatic pulse(input int i);
    @(posedge pclk);
    pins[i] <= 1'b1;
    repeat (4) @(posedge pclk);
    pins[i] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic clear_all(input logic col);
    apb(1'b1, `CPF_OFF_CTRL, {29'h0, col, 2'h3});
    apb(1'b1, `CPF_OFF_CLR, 32'h000000E4);
  endtask
  // reference side: each grant address and punched word follows the window walk
  always @(posedge pclk) begin
    if (mem_gnt && track) begin
      check(32'(mem_addr), 32'(base + 16'(gcount % nwords)), "grant address");
      gcount++;
    end
    if (punch_valid && track && !corrupt) begin
      va = base + 16'(vcount % nwords);
      check(32'(punch_data), {8'h00, ~va[7:0], va}, "punch word");
      vcount++;
    end
    if (feed_card) begin
      feed_n++;
      stk_seen = stacker_sel;
      xlat_seen = punch_xlat;
    end
    if (select_only) begin
      sel_n++;
      stk_seen = stacker_sel;
    end
  end
  // t: op, interrupt, col90, bad residue, hole error, fault, oversight, bad word
  task automatic run_card(input logic [9:0] t);
    logic legal, fetch, fault_x, over_x, data_x, hit;
    int n;
    legal = (t[9:7] inside {`CPF_OP_PC, `CPF_OP_PCT, `CPF_OP_PCS, `CPF_OP_PUNCH_TRANSLATED_STACKER1,
      `CPF_OP_CCS}) && !t[0];
    fetch = legal && t[7];
    seed = xs(seed);
    base = seed[15:0] & 16'hFFC0;
    lat <= seed[17:16];
    nwords = t[5] ? 24 : (t[8] ? 20 : 40);
    {gcount, vcount, feed_n, sel_n, hit, xlat_seen, stk_seen} = '0;
    corrupt <= t[4];
    track = 1'b1;
    // initiation is never cleared by hardware, so drop the previous card's one first
    apb(1'b1, `CPF_OFF_CLR, 32'h00000004);
    apb(1'b1, `CPF_OFF_CTRL, {29'h0, t[5], 2'h1});
    apb(1'b1, `CPF_OFF_FUNC, fword(t[9:7], t[6], base, t[0]));
    apb(1'b0, `CPF_OFF_FUNC, 32'h0);
    check(rd, fword(t[9:7], t[6], base, t[0]), "function readback");
    for (n = 0; n < 3000 && fetch && gcount < (t[5] ? 144 : 240); n++) begin
      @(posedge pclk);
      if (gcount == 10 && (t[2] || t[1]) && !hit) begin
        hit = 1'b1;
        if (t[2]) pulse(2);
        if (t[1]) pulse(3);
      end
    end
    repeat (10) @(posedge pclk);
    if (!hit) check(32'(gcount), fetch ? (t[5] ? 144 : 240) : 0, "grant count");
    apb(1'b0, `CPF_OFF_CNT, 32'h0);
    if (!hit) check(rd, fetch ? (t[5] ? 144 : 240) : 0, "count register");
    if (hit) check(32'(mem_req), 0, "access blocked");
    check(32'(feed_n), 32'(fetch), "feed pulse");
    check(32'(sel_n), 32'(legal && t[9:7] == `CPF_OP_CCS), "select pulse");
    check({stk_seen, xlat_seen}, {t[9] & legal, t[8] & fetch}, "stacker, xlat");
    if (t[3]) pulse(1);
    pulse(0);
    check(32'(stacker_sel), 0, "deflector home");
    fault_x = t[2] || !legal;
    over_x = t[1] && !t[2];
    data_x = (t[4] || t[3]) && !fault_x && !over_x;
    apb(1'b0, `CPF_OFF_STAT, 32'h0);
    check(rd & 32'hE4, {24'h0, fault_x, over_x, data_x, 2'h0, t[6], 2'h0},
      "indicators");
    if (fault_x || over_x || data_x) begin
      corrupt <= 1'b0;
      track = 1'b0;
      hold_sel = sel_n;
      apb(1'b1, `CPF_OFF_FUNC, fword(`CPF_OP_CCS, 1'b0, 16'h0000, 1'b0));
      repeat (20) @(posedge pclk);
      check(32'(sel_n), 32'(hold_sel), "blocked load");
      clear_all(t[5]);
      repeat (1500) @(posedge pclk);
      pulse(0);
      pulse(0);
      clear_all(t[5]);
      apb(1'b0, `CPF_OFF_STAT, 32'h0);
      check(rd & 32'h7E4, 32'h0, "standby drained");
    end
  endtask
  // watchdog: the whole table runs in well under 100k clocks
  initial begin
    #800000;
    err_count++;
    print_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pins, path_busy, corrupt, lat} = '0;
    {err_count, checks_done, gcount, vcount, feed_n, sel_n, track} = '0;
    nwords = 40;
    base = 16'h0000;
    seed = 32'h704A5DC2;
    tbl = '{10'b0011000000, 10'b0110000000, 10'b1010100000, 10'b1111000000,
      10'b1000000000, 10'b0100000000, 10'b0010010000, 10'b0110001100,
      10'b1010110010, 10'b0010000110, 10'b0011000001, 10'b0110101000, 10'b1100000000};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CPF_OFF_STAT, 32'h0);
    check(rd & 32'h7E4, 32'h0, "status at reset");
    apb(1'b0, 8'h20, 32'h0);
    check({rd[30:0], e}, 32'h1, "unmapped read");
    // conditions while idle and empty must not latch; with cards present an oversight must
    apb(1'b1, `CPF_OFF_CTRL, 32'h1);
    pulse(2);
    pulse(3);
    apb(1'b0, `CPF_OFF_STAT, 32'h0);
    check(rd & 32'hE4, 32'h0, "idle conditions");
    path_busy <= 1'b1;
    pulse(3);
    apb(1'b0, `CPF_OFF_STAT, 32'h0);
    check(rd & 32'hE4, 32'h40, "oversight in path");
    clear_all(1'b0);
    path_busy <= 1'b0;
    apb(1'b0, `CPF_OFF_STAT, 32'h0);
    check(rd & 32'hE4, 32'h0, "oversight cleared");
    foreach (tbl[i]) run_card(tbl[i]);
    print_verdict();
  end
endmodule // card_punch_function_control_tb_top
`default_nettype wire
